/* File: hdl/dram_bank_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_bank_timer
    import ddr2_timing_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // Command bus
    ddr_cmd_if.dev            cmd,
    // Bank status
    output logic [NB-1:0]     bank_open,
    output logic [NB-1:0]     bank_idle,
    output logic [NB-1:0]     bank_act_ok,
    output logic [NB-1:0]     ap_start,
    // Refresh status
    output logic              refresh_busy,
    output logic [AW-1:0]     refresh_row
);
    cmd_t          cur;
    logic          ap_bit;
    logic          is_rw;
    cnt_t          rfc_q;
    logic          ref_busy_q;
    logic [AW-1:0] row_q;

    always_comb begin
        cur    = decode_cmd(cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n); // [RL17]
        ap_bit = cmd.addr[AP_BIT];
        is_rw  = (cur == CMD_RD) || (cur == CMD_WR);
    end

    // Refresh ignores the address bus
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rfc_q      <= '0;
            ref_busy_q <= 1'b0;
            row_q      <= ROW_RST;
        end else if (cur == CMD_REF) begin
            rfc_q      <= RFC_LD;
            ref_busy_q <= 1'b1;
            row_q      <= row_q + 1'b1; // [RL18]
        end else begin
            if (rfc_q != '0) begin
                rfc_q <= rfc_q - 1'b1;
            end
            ref_busy_q <= (rfc_q != '0);
        end
    end

    assign refresh_busy = ref_busy_q;
    assign refresh_row  = row_q;

    generate
        for (genvar b = 0; b < NB; b++) begin : g_bank
            logic hit;
            logic pre_hit;
            logic start;
            logic open_q;
            logic pend_q;
            logic start_q;
            logic idle_q;
            logic act_ok_q;
            cnt_t ras_q;
            cnt_t rc_q;
            cnt_t ap_q;
            cnt_t rp_q;

            always_comb begin
                hit     = (cmd.ba == BW'(b));
                pre_hit = (cur == CMD_PRE) && (ap_bit || hit); // [RL23]
                // Waits for row-active and read-to-precharge
                start   = pend_q && (ap_q == '0) && (ras_q == '0) && !pre_hit; // [RL4] [RL22]
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    ras_q <= '0;
                    rc_q  <= '0;
                end else if (cur == CMD_ACT && hit) begin
                    ras_q <= RAS_LD; // [RL24]
                    rc_q  <= RC_LD;
                end else begin
                    if (ras_q != '0) begin
                        ras_q <= ras_q - 1'b1;
                    end
                    if (rc_q != '0) begin
                        rc_q <= rc_q - 1'b1;
                    end
                end
            end

            // Read spacing also covers two clocks past the last prefetch
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    pend_q <= 1'b0;
                    ap_q   <= '0;
                end else if (is_rw && hit) begin
                    pend_q <= ap_bit; // [RL1] [RL2]
                    ap_q   <= (cur == CMD_RD) ? RD_PRE_LD : WR_AP_LD; // [RL3] [RL7] [RL9]
                end else begin
                    if (start || pre_hit || cur == CMD_REF) begin
                        pend_q <= 1'b0;
                    end
                    if (ap_q != '0) begin
                        ap_q <= ap_q - 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    open_q  <= 1'b0;
                    start_q <= 1'b0;
                end else begin
                    start_q <= start;
                    if (cur == CMD_ACT && hit) begin
                        open_q <= 1'b1;
                    end else if (pre_hit || start || cur == CMD_REF) begin
                        open_q <= 1'b0; // [RL20]
                    end
                end
            end

            // Precharge time runs from the start
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    rp_q <= '0;
                end else if (pre_hit || start) begin
                    rp_q <= (pre_hit && ap_bit) ? RPA_LD : RP_LD; // [RL5]
                end else if (rp_q != '0) begin
                    rp_q <= rp_q - 1'b1;
                end
            end

            // Status lags one clock
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    idle_q   <= 1'b1;
                    act_ok_q <= 1'b1;
                end else begin
                    idle_q   <= !open_q && (rp_q == '0) && !ref_busy_q;
                    act_ok_q <= !open_q && (rp_q == '0) && !ref_busy_q && (rc_q == '0); // [RL24]
                end
            end

            assign bank_open[b]   = open_q;
            assign bank_idle[b]   = idle_q;
            assign bank_act_ok[b] = act_ok_q;
            assign ap_start[b]    = start_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hdl/dram_cmd_sched.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: Read/write without close bit leaves bank open
// RL2: Close bit high enables automatic bank precharge
// RL3: Read auto-close starts at AL plus BL/2
// RL4: Start waits for row-active and read-to-precharge
// RL5: Precharge time counts from actual start moment
// RL6: Read auto-close to activate: AL+tRTP+tRP
// RL7: Auto-close never before two clocks past prefetch
// RL8: Reactivate after precharge time and row cycle
// RL9: Write auto-close after burst plus write recovery
// RL10: Write auto-close reactivate after last_data_to_activate_delay
// RL11: Read to precharge: AL+BL/2+max(RTP,2)-2
// RL12: Write to precharge: WL+BL/2+recovery
// RL13: Precharge to precharge needs one clock
// RL14: Read-to-precharge cycles rounded up
// RL15: Precharge period per bank from latest precharge
// RL16: Refresh on average every 7.8 us
// RL17: Refresh is CS, RAS, CAS low, WE high
// RL18: Refresh rows come from internal counter
// RL19: All banks idle tRP before refresh
// RL20: Refresh leaves banks idle; wait refresh cycle
// RL21: At most eight refreshes postponed
// RL22: Auto-close held off until array restore done
// RL23: Close bit picks all banks, else bank number
// RL24: Per-bank row-active, precharge, row-cycle timers
module dram_cmd_sched
    import ddr2_timing_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // User requests
    input  wire logic          req_valid,
    input  wire cmd_t          req_cmd,
    input  wire logic [BW-1:0] req_bank,
    input  wire logic [AW-1:0] req_addr,
    output logic               req_taken,
    // Refresh status
    output logic               refresh_due,
    output logic [OWED_W-1:0]  refresh_owed,
    // Command bus
    ddr_cmd_if.ctl             cmd
);
    logic [NB-1:0]     open_v;
    logic [NB-1:0]     prew_zero;
    logic [NB-1:0]     actw_zero;
    logic              all_pre_ok;
    logic              none_open;
    logic              banks_rest;
    logic              legal;
    logic              do_ref;
    logic              force_pre;
    logic              take;
    cmd_t              issue_cmd;
    logic [BW-1:0]     issue_bank;
    logic [AW-1:0]     issue_addr;
    logic              issue_ap;
    logic              taken_q;
    logic              due_q;
    logic [OWED_W-1:0] owed_q;
    cnt_t              refi_q;
    cnt_t              rfc_q;
    logic [3:0]        pins_q;
    logic [AW-1:0]     addr_q;
    logic [BW-1:0]     ba_q;

    always_comb begin
        all_pre_ok = &prew_zero; // [RL13]
        none_open  = ~|open_v;
        banks_rest = &actw_zero;
        // Refresh only once every bank has closed and rested
        do_ref     = (owed_q != '0) && none_open && banks_rest && (rfc_q == '0); // [RL19] [RL20]
        // Eight owed: close all so the refresh can go out
        force_pre  = (owed_q >= OWED_W'(REF_POST_MAX)) && !none_open && all_pre_ok; // [RL21]
        case (req_cmd)
            CMD_ACT: legal = !open_v[req_bank] && actw_zero[req_bank] && (rfc_q == '0)
                             && (owed_q < OWED_W'(REF_POST_MAX)); // [RL8] [RL20] [RL21]
            CMD_RD:  legal = open_v[req_bank];
            CMD_WR:  legal = open_v[req_bank];
            CMD_PRE: legal = req_addr[AP_BIT] ? all_pre_ok : prew_zero[req_bank]; // [RL11] [RL12] [RL23]
            default: legal = 1'b0;
        endcase
        take = req_valid && !taken_q && legal && !do_ref && !force_pre;
        if (do_ref) begin
            issue_cmd  = CMD_REF;
            issue_bank = '0;
            issue_addr = '0;
        end else if (force_pre) begin
            issue_cmd  = CMD_PRE;
            issue_bank = '0;
            issue_addr = '0;
            issue_addr[AP_BIT] = 1'b1; // [RL23]
        end else if (take) begin
            issue_cmd  = req_cmd;
            issue_bank = req_bank;
            issue_addr = req_addr;
        end else begin
            issue_cmd  = CMD_NOP;
            issue_bank = '0;
            issue_addr = '0;
        end
        issue_ap = issue_addr[AP_BIT];
    end

    generate
        for (genvar b = 0; b < NB; b++) begin : g_bank
            logic hit;
            logic pre_hit;
            logic open_q;
            cnt_t prew_q;
            cnt_t actw_q;

            always_comb begin
                hit     = (issue_bank == BW'(b));
                pre_hit = (issue_cmd == CMD_PRE) && (issue_ap || hit);
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    open_q <= 1'b0;
                end else if (issue_cmd == CMD_ACT && hit) begin
                    open_q <= 1'b1;
                end else if ((issue_cmd == CMD_RD || issue_cmd == CMD_WR) && hit && issue_ap) begin
                    open_q <= 1'b0;
                end else if (pre_hit) begin
                    open_q <= 1'b0;
                end
            end

            // Earliest explicit precharge to this bank
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    prew_q <= '0;
                end else if (issue_cmd == CMD_ACT && hit) begin
                    prew_q <= RAS_LD;
                end else if (issue_cmd == CMD_RD && hit) begin
                    prew_q <= cmax(prew_q, RD_PRE_LD); // [RL11] [RL14]
                end else if (issue_cmd == CMD_WR && hit) begin
                    prew_q <= cmax(prew_q, issue_ap ? WR_AP_LD : WR_PRE_LD); // [RL12]
                end else if (prew_q != '0) begin
                    prew_q <= prew_q - 1'b1;
                end
            end

            // Earliest activate to this bank
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    actw_q <= '0;
                end else if (issue_cmd == CMD_ACT && hit) begin
                    actw_q <= RC_LD; // [RL8] [RL10]
                end else if (issue_cmd == CMD_RD && hit && issue_ap) begin
                    actw_q <= cmax(actw_q, RD_ACT_LD); // [RL6] [RL8]
                end else if (issue_cmd == CMD_WR && hit && issue_ap) begin
                    actw_q <= cmax(actw_q, WR_ACT_LD); // [RL10]
                end else if (pre_hit) begin
                    actw_q <= cmax(actw_q, issue_ap ? RPA_LD : RP_LD); // [RL15]
                end else if (actw_q != '0) begin
                    actw_q <= actw_q - 1'b1;
                end
            end

            assign open_v[b]    = open_q;
            assign prew_zero[b] = (prew_q == '0);
            assign actw_zero[b] = (actw_q == '0);
        end
    endgenerate

    // Interval rounds down to keep the average short
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            refi_q <= REFI_LD;
        end else if (refi_q == '0) begin
            refi_q <= REFI_LD; // [RL16]
        end else begin
            refi_q <= refi_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            owed_q <= '0;
        end else if (refi_q == '0 && !do_ref) begin
            if (owed_q != 4'hf) begin
                owed_q <= owed_q + 1'b1;
            end
        end else if (refi_q != '0 && do_ref) begin
            owed_q <= owed_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rfc_q <= '0;
        end else if (do_ref) begin
            rfc_q <= RFC_LD; // [RL20]
        end else if (rfc_q != '0) begin
            rfc_q <= rfc_q - 1'b1;
        end
    end

    // Deselect when nothing is issued
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pins_q  <= 4'hf;
            addr_q  <= '0;
            ba_q    <= '0;
            taken_q <= 1'b0;
            due_q   <= 1'b0;
        end else begin
            pins_q  <= cmd_pins(issue_cmd); // [RL17]
            addr_q  <= issue_addr;
            ba_q    <= issue_bank;
            taken_q <= take;
            due_q   <= (owed_q != '0);
        end
    end

    assign cmd.cs_n     = pins_q[3];
    assign cmd.ras_n    = pins_q[2];
    assign cmd.cas_n    = pins_q[1];
    assign cmd.we_n     = pins_q[0];
    assign cmd.addr     = addr_q;
    assign cmd.ba       = ba_q;
    assign req_taken    = taken_q;
    assign refresh_due  = due_q;
    assign refresh_owed = owed_q;
endmodule
`default_nettype wire

/* File: include/ddr2_timing_pkg.sv */
package ddr2_timing_pkg;
    // Geometry
    localparam int NB     = 8;
    localparam int BW     = 3;
    localparam int AW     = 14;
    localparam int AP_BIT = 10;
    localparam int REF_POST_MAX = 8;
    localparam int OWED_W = 4;

    // Programmed latencies
    localparam int AL = 2;
    localparam int CL = 3;
    localparam int WL = AL + CL - 1;
    localparam int BL = 4;
    localparam int WR = 3;

    // Analog times in picoseconds, refresh window in milliseconds
    localparam int T_CK_PS   = 100000;
    localparam int T_RAS_PS  = 45000;
    localparam int T_RC_PS   = 60000;
    localparam int T_RP_PS   = 15000;
    localparam int T_RPA_PS  = 17500;
    localparam int T_RTP_PS  = 7500;
    localparam int T_WR_PS   = 15000;
    localparam int T_RFC_PS  = 127500;
    localparam int T_REFI_PS = 7800000;
    localparam int REF_WINDOW_MS = 64;

    // Least times round up, the refresh interval rounds down
    localparam int RAS_CYC  = (T_RAS_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int RC_CYC   = (T_RC_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int RP_CYC   = (T_RP_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int RPA_CYC  = (T_RPA_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int RTP_CYC  = (T_RTP_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int TWR_CYC  = (T_WR_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int RFC_CYC  = (T_RFC_PS + T_CK_PS - 1) / T_CK_PS;
    localparam int REFI_CYC = T_REFI_PS / T_CK_PS;
    localparam int RTP2_CYC = (RTP_CYC > 2) ? RTP_CYC : 2;

    // Least command spacings in cycles
    localparam int RD_PRE_CYC    = AL + BL / 2 + RTP2_CYC - 2;
    localparam int WR_PRE_CYC    = WL + BL / 2 + TWR_CYC;
    localparam int WR_AP_PRE_CYC = WL + BL / 2 + WR;
    localparam int RD_AP_ACT_CYC = RD_PRE_CYC + RP_CYC;
    localparam int DAL_CYC       = WR + RP_CYC;
    localparam int WR_AP_ACT_CYC = WL + BL / 2 + DAL_CYC;

    typedef logic [7:0] cnt_t;

    // Counter loads: a spacing of S cycles loads S-1
    localparam cnt_t RAS_LD      = cnt_t'(RAS_CYC - 1);
    localparam cnt_t RC_LD       = cnt_t'(RC_CYC - 1);
    localparam cnt_t RP_LD       = cnt_t'(RP_CYC - 1);
    localparam cnt_t RPA_LD      = cnt_t'(RPA_CYC - 1);
    localparam cnt_t RFC_LD      = cnt_t'(RFC_CYC - 1);
    localparam cnt_t REFI_LD     = cnt_t'(REFI_CYC - 1);
    localparam cnt_t RD_PRE_LD   = cnt_t'(RD_PRE_CYC - 1);
    localparam cnt_t WR_PRE_LD   = cnt_t'(WR_PRE_CYC - 1);
    localparam cnt_t WR_AP_LD    = cnt_t'(WR_AP_PRE_CYC - 1);
    localparam cnt_t RD_ACT_LD   = cnt_t'(RD_AP_ACT_CYC - 1);
    localparam cnt_t WR_ACT_LD   = cnt_t'(WR_AP_ACT_CYC - 1);
    localparam logic [AW-1:0] ROW_RST = 14'h0000;

    typedef enum logic [2:0] {
        CMD_NOP   = 3'h0,
        CMD_ACT   = 3'h1,
        CMD_RD    = 3'h2,
        CMD_WR    = 3'h3,
        CMD_PRE   = 3'h4,
        CMD_REF   = 3'h5,
        CMD_OTHER = 3'h6
    } cmd_t;

    function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        cmd_t c;
        c = CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3:    c = CMD_ACT;
                3'h5:    c = CMD_RD;
                3'h4:    c = CMD_WR;
                3'h2:    c = CMD_PRE;
                3'h1:    c = CMD_REF;
                3'h7:    c = CMD_NOP;
                default: c = CMD_OTHER;
            endcase
        end
        return c;
    endfunction

    // Pin pattern {cs_n, ras_n, cas_n, we_n}
    function automatic logic [3:0] cmd_pins(input cmd_t c);
        logic [3:0] p;
        case (c)
            CMD_ACT: p = 4'h3;
            CMD_RD:  p = 4'h5;
            CMD_WR:  p = 4'h4;
            CMD_PRE: p = 4'h2;
            CMD_REF: p = 4'h1;
            default: p = 4'hf;
        endcase
        return p;
    endfunction

    function automatic cnt_t cmax(input cnt_t a, input cnt_t b);
        return (a > b) ? a : b;
    endfunction
endpackage

/* File: include/ddr_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ddr_cmd_if
    import ddr2_timing_pkg::*;
();
    logic          cs_n;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic [AW-1:0] addr;
    logic [BW-1:0] ba;

    modport ctl (output cs_n, output ras_n, output cas_n, output we_n, output addr, output ba);
    modport dev (input cs_n, input ras_n, input cas_n, input we_n, input addr, input ba);
endinterface
`default_nettype wire

/* File: tb/ddr2_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr2_link_props
    import ddr2_timing_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Command bus
    input  wire logic          cs_n,
    input  wire logic          ras_n,
    input  wire logic          cas_n,
    input  wire logic          we_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [BW-1:0] ba,
    // Device status
    input  wire logic [NB-1:0] bank_open,
    input  wire logic [NB-1:0] ap_start,
    input  wire logic          refresh_busy,
    input  wire logic [AW-1:0] refresh_row
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic       act_c;
    logic       rd_c;
    logic       wr_c;
    logic       pre_c;
    logic       ref_c;
    logic       close_c;
    logic [9:0] gap_q;

    assign act_c   = !cs_n && !ras_n && cas_n && we_n;
    assign rd_c    = !cs_n && ras_n && !cas_n && we_n;
    assign wr_c    = !cs_n && ras_n && !cas_n && !we_n;
    assign pre_c   = !cs_n && !ras_n && cas_n && !we_n;
    assign ref_c   = !cs_n && !ras_n && !cas_n && we_n;
    assign close_c = addr[AP_BIT];

    // Saturates so a lost refresh cannot wrap
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ref_c) begin
            gap_q <= '0;
        end else if (gap_q != 10'h3ff) begin
            gap_q <= gap_q + 10'h1;
        end
    end

    for (genvar i = 0; i < NB; i++) begin : g_bank
        logic sel;
        logic hit;
        assign sel = (ba == BW'(i));
        assign hit = pre_c && (close_c || sel);
        a_act_opens_bank: assert property (act_c && sel |-> ##[1:2] bank_open[i])
            else $error("activate left bank closed");
        a_read_keeps_open: assert property (rd_c && sel && !close_c |-> ##1 bank_open[i] [*3])
            else $error("plain read closed bank");
        a_read_close_start: assert property (
            rd_c && sel && close_c |-> !ap_start[i] [*3] ##[1:5] ap_start[i])
            else $error("read close start off");
        a_write_close_start: assert property (
            wr_c && sel && close_c |-> !ap_start[i] [*8] ##[1:5] ap_start[i])
            else $error("write close start off");
        a_precharge_closes: assert property (hit |-> ##[1:2] !bank_open[i])
            else $error("precharge left bank open");
        a_read_pre_gap: assert property (rd_c && sel |-> ##1 !hit [*3])
            else $error("precharge too soon after read");
        a_write_pre_gap: assert property (wr_c && sel |-> ##1 !hit [*6])
            else $error("precharge too soon after write");
        a_rdap_act_gap: assert property (rd_c && sel && close_c |-> ##1 !(act_c && sel) [*3])
            else $error("read close to activate short");
        a_wrap_act_gap: assert property (wr_c && sel && close_c |-> ##1 !(act_c && sel) [*8])
            else $error("write close to activate short");
    end

    a_refresh_cycle: assert property (
        ref_c |-> ##[1:2] refresh_busy ##[1:6] (!refresh_busy && bank_open == '0))
        else $error("refresh not idle at end");
    a_refresh_spacing: assert property (ref_c |-> ##1 !(ref_c || act_c))
        else $error("command inside refresh");
    a_refresh_row_step: assert property (ref_c |-> ##2 refresh_row == $past(refresh_row, 2) + 14'h1)
        else $error("refresh row step");
    a_refresh_interval: assert property (gap_q <= 10'(9 * REFI_CYC))
        else $error("refresh gap too long");

    c_read_close: cover property (rd_c && close_c);
    c_write_close: cover property (wr_c && close_c);
    c_precharge_all: cover property (pre_c && close_c);
    c_refresh: cover property (ref_c);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ddr2_timing_pkg::*;
();
    logic              ref_clk   = 1'b0;
    logic              rst_n     = 1'b0;
    logic              req_valid = 1'b0;
    cmd_t              req_cmd   = CMD_NOP;
    logic [BW-1:0]     req_bank  = '0;
    logic [AW-1:0]     req_addr  = '0;
    logic              req_taken;
    logic              refresh_due;
    logic [OWED_W-1:0] refresh_owed;
    logic [NB-1:0]     bank_open, bank_idle, bank_act_ok, ap_start;
    logic [NB-1:0]     raw_open;
    logic              refresh_busy, raw_busy;
    logic [AW-1:0]     refresh_row, raw_row;
    int                fails = 0;
    int                total_checks = 0;
    int                cyc = 0;
    int                t_last = 0;

    ddr_cmd_if link ();
    ddr_cmd_if raw ();

    always #50 ref_clk = ~ref_clk;

    dram_cmd_sched dram_cmd_sched_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_bank(req_bank), .req_addr(req_addr), .req_taken(req_taken), .refresh_due(refresh_due),
        .refresh_owed(refresh_owed), .cmd(link.ctl));
    dram_bank_timer dram_bank_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(link.dev), .bank_open(bank_open),
        .bank_idle(bank_idle), .bank_act_ok(bank_act_ok), .ap_start(ap_start), .refresh_busy(refresh_busy),
        .refresh_row(refresh_row));
    // Bench-fed end for raw patterns
    dram_bank_timer dram_bank_timer_i2 (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(raw.dev), .bank_open(raw_open),
        .bank_idle(), .bank_act_ok(), .ap_start(), .refresh_busy(raw_busy),
        .refresh_row(raw_row));
    ddr2_link_props ddr2_link_props_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr), .ba(link.ba), .bank_open(bank_open),
        .ap_start(ap_start), .refresh_busy(refresh_busy), .refresh_row(refresh_row));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until taken; checks the bus in that cycle
    task automatic issue(input cmd_t c, input int b, input logic ap, input logic [3:0] pins);
        int          n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = BW'(b);
        req_addr = {3'h0, ap, 10'h000};
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (req_taken !== 1'b1 && n < 300);
        req_valid = 1'b0;
        check("command pins", 16'({link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr[AP_BIT]}),
              16'({pins, BW'(b), ap}));
        t_last = cyc;
    endtask

    task automatic wait_ap(input int b, output int n);
        n = 0;
        while (ap_start[b] !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic raw_cmd(input logic [3:0] pins, input logic [BW-1:0] b, input logic [AW-1:0] a);
        @(negedge ref_clk);
        {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} = pins;
        raw.ba = b;
        raw.addr = a;
        @(negedge ref_clk);
        {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} = 4'hf;
        // A released address bus must not look stable
        raw.addr = ~a;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 4000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        int          n;
        int          t0;
        logic [AW-1:0] row0;
        {raw.cs_n, raw.ras_n, raw.cas_n, raw.we_n} = 4'hf;
        raw.addr = '0;
        raw.ba = '0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        check("bus idle", 16'({link.cs_n, link.ras_n, link.cas_n, link.we_n}), 16'h000f);
        check("idle banks", 16'(bank_idle), 16'h00ff);
        for (int b = 0; b < NB; b++) issue(CMD_ACT, b, 1'b0, 4'h3);
        repeat (3) @(negedge ref_clk);
        check("open after activate", 16'(bank_open), 16'h00ff);
        issue(CMD_RD, 0, 1'b0, 4'h5);
        issue(CMD_RD, 1, 1'b1, 4'h5);
        t0 = t_last;
        wait_ap(1, n);
        check("read close start", 16'(n >= AL + BL / 2 + 1 && n <= AL + BL / 2 + 3), 16'h1);
        issue(CMD_ACT, 1, 1'b0, 4'h3);
        check("read close to activate", 16'(t_last - t0 >= AL + RTP_CYC + RP_CYC), 16'h1);
        issue(CMD_WR, 2, 1'b1, 4'h4);
        t0 = t_last;
        wait_ap(2, n);
        check("write close start", 16'(n >= WL + BL / 2 + WR + 1 && n <= WL + BL / 2 + WR + 3), 16'h1);
        issue(CMD_ACT, 2, 1'b0, 4'h3);
        check("write close to activate", 16'(t_last - t0 >= WL + BL / 2 + WR + RP_CYC), 16'h1);
        issue(CMD_RD, 3, 1'b0, 4'h5);
        t0 = t_last;
        issue(CMD_PRE, 3, 1'b0, 4'h2);
        check("read to precharge", 16'(t_last - t0 >= AL + BL / 2 + RTP2_CYC - 2), 16'h1);
        issue(CMD_WR, 4, 1'b0, 4'h4);
        t0 = t_last;
        issue(CMD_PRE, 4, 1'b0, 4'h2);
        check("write to precharge", 16'(t_last - t0 >= WL + BL / 2 + TWR_CYC), 16'h1);
        issue(CMD_PRE, 5, 1'b0, 4'h2);
        issue(CMD_PRE, 6, 1'b0, 4'h2);
        repeat (3) @(negedge ref_clk);
        check("single bank close", 16'(bank_open), 16'h0087);
        issue(CMD_PRE, 0, 1'b1, 4'h2);
        repeat (3) @(negedge ref_clk);
        check("all banks closed", 16'(bank_open), 16'h0000);
        n = 0;
        while ({link.cs_n, link.ras_n, link.cas_n, link.we_n} !== 4'h1 && n < 800) begin
            @(negedge ref_clk);
            n++;
        end
        row0 = refresh_row;
        check("refresh issued", 16'(n < 800), 16'h1);
        check("refresh count", 16'({refresh_due, refresh_owed}), 16'h0010);
        repeat (2) @(negedge ref_clk);
        check("refresh row step", 16'(refresh_row), 16'(row0 + 14'h1));
        repeat (10) @(negedge ref_clk);
        check("idle after refresh", 16'({bank_act_ok, bank_idle}), 16'hffff);
        raw_cmd(4'h1, 3'h7, 14'h3fff);
        repeat (2) @(negedge ref_clk);
        check("raw refresh row", 16'(raw_row), 16'h0001);
        raw_cmd(4'h0, 3'h2, 14'h0400);
        repeat (3) @(negedge ref_clk);
        check("other pattern ignored", 16'({raw_open, raw_busy}), 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
